// ==== hdl/gpb_pkg.sv ====
// Package with register map, field layout and bus constants of the port pair
`default_nettype none

package gpb_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 10;

    // ----------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------
    localparam logic [IDX_W-1:0] IDX_PA_DATA = 10'h0C0;
    localparam logic [IDX_W-1:0] IDX_PB_DATA = 10'h0C1;
    localparam logic [IDX_W-1:0] IDX_PA_DIR  = 10'h0C4;
    localparam logic [IDX_W-1:0] IDX_PB_DIR  = 10'h0C5;
    localparam logic [IDX_W-1:0] IDX_PA_OPT  = 10'h0CC;
    localparam logic [IDX_W-1:0] IDX_PB_OPT  = 10'h0CD;
    localparam logic [IDX_W-1:0] IDX_CTRL    = 10'h0D0;

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int              CTRL_GEN_BIT = 0;
    localparam logic [PORT_W-1:0] PORT_RST   = 8'h00;
    localparam logic            GEN_RST      = 1'h0;

    // Pins able to reach the converter input
    localparam logic [PORT_W-1:0] PA_ANALOG_MASK = 8'h00;
    localparam logic [PORT_W-1:0] PB_ANALOG_MASK = 8'hE8;

    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpb_pkg

`default_nettype wire

// ==== hdl/gpb_pin_cell.sv ====
// Mode decoder and pad driver control for one port pin
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_cell (
    input  wire logic dirBit,
    input  wire logic optBit,
    input  wire logic datBit,
    input  wire logic analogOk,
    output logic      pullUpEn,
    output logic      irqSel,
    output logic      analogSel,
    output logic      drvOe,
    output logic      drvVal
);

    // ----------------------------------------
    // Input modes
    // ----------------------------------------
    always_comb begin
        pullUpEn  = !dirBit && !datBit;
        irqSel    = !dirBit && optBit && !datBit;
        analogSel = !dirBit && optBit && datBit && analogOk;
        if (!dirBit && !optBit && datBit) begin
            pullUpEn = 1'b0;
        end
    end

    // ----------------------------------------
    // Output modes
    // ----------------------------------------
    always_comb begin
        drvVal = 1'b0;
        drvOe  = 1'b0;
        if (dirBit) begin
            if (optBit) begin
                drvOe  = 1'b1;
                drvVal = datBit;
            end else begin
                drvOe  = !datBit;
                drvVal = 1'b0;
            end
        end
    end

endmodule // gpb_pin_cell

`default_nettype wire

// ==== hdl/gpb_port_pair.sv ====
// Two 8-bit I/O ports with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Configuration 000 gives input with pull-up and no interrupt.
// - Configuration 001 gives input without pull-up and without interrupt.
// - Configuration 010 gives input with pull-up routed to interrupt logic.
// - Configuration 011 connects an analog-capable pin to the converter.
// - Output with option zero is open drain, high side off.
// - Output with option one is push-pull carrying the latch value.
// - Data read gives latch for outputs and pin level for inputs.
// - Data write in input mode updates latch and thus input mode.
// - Reset clears all port registers, pins become pulled-up inputs.
// - Port data registers sit at indices 0C0h and 0C1h.
// - Direction registers at 0C4h and 0C5h, one means output.
// - Option registers at 0CCh and 0CDh, output type select.
// - Interrupt only when pin selects interrupt and global enable set.
// - Wait and stop keep port state; enabled interrupt requests wake, but a pin falling while ce is low is not sampled and raises no wakeReq.
// - Bit n of each data, direction and option register controls pin n of its port.
// - Output latch zero drives low; one drives high or floats.
module gpb_port_pair
    import gpb_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic [gpb_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [gpb_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [gpb_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [gpb_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [gpb_pkg::PORT_W-1:0]  portAPinIn,
    output logic [gpb_pkg::PORT_W-1:0]       portAPinOut,
    output logic [gpb_pkg::PORT_W-1:0]       portAPinOe,
    output logic [gpb_pkg::PORT_W-1:0]       portAPullUp,
    output logic [gpb_pkg::PORT_W-1:0]       portAAnalog,
    output logic [gpb_pkg::PORT_W-1:0]       portAExtIrq,
    input  wire logic [gpb_pkg::PORT_W-1:0]  portBPinIn,
    output logic [gpb_pkg::PORT_W-1:0]       portBPinOut,
    output logic [gpb_pkg::PORT_W-1:0]       portBPinOe,
    output logic [gpb_pkg::PORT_W-1:0]       portBPullUp,
    output logic [gpb_pkg::PORT_W-1:0]       portBAnalog,
    output logic [gpb_pkg::PORT_W-1:0]       portBExtIrq,
    output logic                             wakeReq
);
    import gpb_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0] dataA;
        logic [PORT_W-1:0] dataB;
        logic [PORT_W-1:0] dirA;
        logic [PORT_W-1:0] dirB;
        logic [PORT_W-1:0] optA;
        logic [PORT_W-1:0] optB;
        logic              gen;
        logic              awHeld;
        logic [IDX_W-1:0]  awIdx;
        logic              wHeld;
        logic [PORT_W-1:0] wByte;
        logic              wLane0;
        logic              bValid;
        logic [1:0]        bResp;
        logic              rValid;
        logic [DATA_W-1:0] rData;
        logic [1:0]        rResp;
        logic [PORT_W-1:0] syncA1;
        logic [PORT_W-1:0] syncA2;
        logic [PORT_W-1:0] syncB1;
        logic [PORT_W-1:0] syncB2;
    } gpb_state_s;

    gpb_state_s        st;
    gpb_state_s        next_st;
    logic              doWrite;
    logic [PORT_W-1:0] readA;
    logic [PORT_W-1:0] readB;
    logic [PORT_W-1:0] irqSelA;
    logic [PORT_W-1:0] irqSelB;

    // ----------------------------------------
    // Pin cells
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            gpb_pin_cell u_cell_a (
                .dirBit    (st.dirA[gi]),
                .optBit    (st.optA[gi]),
                .datBit    (st.dataA[gi]),
                .analogOk  (PA_ANALOG_MASK[gi]),
                .pullUpEn  (portAPullUp[gi]),
                .irqSel    (irqSelA[gi]),
                .analogSel (portAAnalog[gi]),
                .drvOe     (portAPinOe[gi]),
                .drvVal    (portAPinOut[gi])
            );
            gpb_pin_cell u_cell_b (
                .dirBit    (st.dirB[gi]),
                .optBit    (st.optB[gi]),
                .datBit    (st.dataB[gi]),
                .analogOk  (PB_ANALOG_MASK[gi]),
                .pullUpEn  (portBPullUp[gi]),
                .irqSel    (irqSelB[gi]),
                .analogSel (portBAnalog[gi]),
                .drvOe     (portBPinOe[gi]),
                .drvVal    (portBPinOut[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Interrupt lines and wake
    // ----------------------------------------
    always_comb begin
        portAExtIrq = st.gen ? (irqSelA & ~st.syncA2) : PORT_RST;
        portBExtIrq = st.gen ? (irqSelB & ~st.syncB2) : PORT_RST;
        wakeReq     = (|portAExtIrq) || (|portBExtIrq);
    end

    // ----------------------------------------
    // Read view of data registers
    // ----------------------------------------
    always_comb begin
        readA = (st.dirA & st.dataA) | (~st.dirA & st.syncA2);
        readB = (st.dirB & st.dataB) | (~st.dirB & st.syncB2);
    end

    // ----------------------------------------
    // Bus handshakes
    // ----------------------------------------
    always_comb begin
        // Bus goes silent while frozen, so no beat is taken and lost
        s_axi_awready = ce && !st.awHeld && !st.bValid;
        s_axi_wready  = ce && !st.wHeld && !st.bValid;
        s_axi_arready = ce && !st.rValid;
        s_axi_bvalid  = ce && st.bValid;
        s_axi_bresp   = st.bResp;
        s_axi_rvalid  = ce && st.rValid;
        s_axi_rdata   = st.rData;
        s_axi_rresp   = st.rResp;
        doWrite       = st.awHeld && st.wHeld && !st.bValid;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st        = st;
        next_st.syncA1 = portAPinIn;
        next_st.syncA2 = st.syncA1;
        next_st.syncB1 = portBPinIn;
        next_st.syncB2 = st.syncB1;

        if (s_axi_awvalid && s_axi_awready) begin
            next_st.awHeld = 1'b1;
            next_st.awIdx  = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.wHeld  = 1'b1;
            next_st.wByte  = s_axi_wdata[PORT_W-1:0];
            next_st.wLane0 = s_axi_wstrb[0];
        end

        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = RESP_OKAY;
            unique case (st.awIdx)
                IDX_PA_DATA: if (st.wLane0) next_st.dataA = st.wByte;
                IDX_PB_DATA: if (st.wLane0) next_st.dataB = st.wByte;
                IDX_PA_DIR:  if (st.wLane0) next_st.dirA  = st.wByte;
                IDX_PB_DIR:  if (st.wLane0) next_st.dirB  = st.wByte;
                IDX_PA_OPT:  if (st.wLane0) next_st.optA  = st.wByte;
                IDX_PB_OPT:  if (st.wLane0) next_st.optB  = st.wByte;
                IDX_CTRL:    if (st.wLane0) next_st.gen   = st.wByte[CTRL_GEN_BIT];
                default:     next_st.bResp = RESP_SLVERR;
            endcase
        end else if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rValid = 1'b1;
            next_st.rResp  = RESP_OKAY;
            next_st.rData  = '0;
            unique case (s_axi_araddr[ADDR_W-1:2])
                IDX_PA_DATA: next_st.rData[PORT_W-1:0] = readA;
                IDX_PB_DATA: next_st.rData[PORT_W-1:0] = readB;
                IDX_PA_DIR:  next_st.rData[PORT_W-1:0] = st.dirA;
                IDX_PB_DIR:  next_st.rData[PORT_W-1:0] = st.dirB;
                IDX_PA_OPT:  next_st.rData[PORT_W-1:0] = st.optA;
                IDX_PB_OPT:  next_st.rData[PORT_W-1:0] = st.optB;
                IDX_CTRL:    next_st.rData[CTRL_GEN_BIT] = st.gen;
                default:     next_st.rResp = RESP_SLVERR;
            endcase
        end else if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers, held through wait and stop
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st       <= '0;
            st.dataA <= PORT_RST;
            st.dataB <= PORT_RST;
            st.dirA  <= PORT_RST;
            st.dirB  <= PORT_RST;
            st.optA  <= PORT_RST;
            st.optB  <= PORT_RST;
            st.gen   <= GEN_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    pullUpDecode_a: assert property (
        ((~st.dirA & ~st.optA & ~st.dataA) & ~portAPullUp) == PORT_RST
    ) else $error("pull-up missing in reset input mode");

    noPullDecode_a: assert property (
        ((~st.dirB & ~st.optB & st.dataB) & (portBPullUp | irqSelB)) == PORT_RST
    ) else $error("plain input still pulled or interrupting");

    irqDecode_a: assert property (
        irqSelA == (~st.dirA & st.optA & ~st.dataA)
        && (irqSelA & ~portAPullUp) == PORT_RST
    ) else $error("interrupt input decode wrong");

    analogDecode_a: assert property (
        portBAnalog == (~st.dirB & st.optB & st.dataB & PB_ANALOG_MASK)
    ) else $error("analog select decode wrong");

    openDrain_a: assert property (
        ((st.dirA & ~st.optA) & (portAPinOut | (portAPinOe & st.dataA))) == PORT_RST
    ) else $error("open drain drives high");

    pushPull_a: assert property (
        ((st.dirB & st.optB) & (~portBPinOe | (portBPinOut ^ st.dataB))) == PORT_RST
    ) else $error("push-pull output not following latch");

    readBack_a: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == IDX_PA_DATA && ce)
        |=> st.rValid && st.rData[PORT_W-1:0] == $past(readA)
    ) else $error("data read mixes latch and pin wrongly");

    resetClear_a: assert property (@(posedge core_clk) disable iff (1'b0)
        !nrst |-> (st.dataA | st.dataB | st.dirA | st.dirB | st.optA | st.optB) == PORT_RST
    ) else $error("port registers not cleared by reset");

    dataWrite_a: assert property (
        (doWrite && ce && st.awIdx == IDX_PA_DATA && st.wLane0)
        |=> st.dataA == $past(st.wByte) && st.bValid
    ) else $error("data write lost");

    dirWrite_a: assert property (
        (doWrite && ce && st.awIdx == IDX_PB_DIR && st.wLane0)
        |=> st.dirB == $past(st.wByte)
    ) else $error("direction write lost");

    irqGate_a: assert property (
        (portAExtIrq != PORT_RST || portBExtIrq != PORT_RST) |-> st.gen && wakeReq
    ) else $error("interrupt raised without global enable");

    dataBWrite_a: assert property (
        (doWrite && ce && st.awIdx == IDX_PB_DATA && st.wLane0)
        |=> st.dataB == $past(st.wByte)
    ) else $error("port B data write lost");

    optWrite_a: assert property (
        (doWrite && ce && st.awIdx == IDX_PB_OPT && st.wLane0)
        |=> st.optB == $past(st.wByte)
    ) else $error("option write lost");

    readBackB_a: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == IDX_PB_DATA && ce)
        |=> st.rValid && st.rData[PORT_W-1:0] == $past(readB)
    ) else $error("port B data read mixes latch and pin wrongly");

    freezeHold_a: assert property (
        !ce |=> $stable(st)
    ) else $error("state moved while frozen");

    genGate_a: assert property (
        !st.gen |-> portAExtIrq == PORT_RST && portBExtIrq == PORT_RST
    ) else $error("interrupt line active with global enable off");

    pullUpB_a: assert property (
        ((~st.dirB & ~st.optB & ~st.dataB) & ~portBPullUp) == PORT_RST
    ) else $error("port B pull-up missing in reset input mode");

    drainLow_a: assert property (
        ((st.dirB & ~st.optB & ~st.dataB) & (~portBPinOe | portBPinOut)) == PORT_RST
    ) else $error("open drain output not driving low");

    analogA_a: assert property (
        portAAnalog == (~st.dirA & st.optA & st.dataA & PA_ANALOG_MASK)
    ) else $error("port A analog select decode wrong");

    respHold_a: assert property (
        (st.bValid && ce && !s_axi_bready) |=> st.bValid
    ) else $error("write response dropped before taken");

    writeCov_c:  cover property (doWrite && ce ##1 s_axi_bvalid && s_axi_bready);
    readCov_c:   cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rready);
    irqCov_c:    cover property (wakeReq);
    analogCov_c: cover property (portBAnalog != PORT_RST);
    freezeCov_c: cover property (!ce ##1 ce);

endmodule // gpb_port_pair

`default_nettype wire

// ==== bench/gpb_pin_model.sv ====
// Pad and board model of one port: drivers, pull-ups, external sources
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_model
    import gpb_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic [gpb_pkg::PORT_W-1:0]  pinOe,
    input  wire logic [gpb_pkg::PORT_W-1:0]  pinOut,
    input  wire logic [gpb_pkg::PORT_W-1:0]  pullUp,
    input  wire logic [gpb_pkg::PORT_W-1:0]  extEn,
    input  wire logic [gpb_pkg::PORT_W-1:0]  extVal,
    output logic [gpb_pkg::PORT_W-1:0]       pinLvl
);
    // Undriven pin without pull-up wanders every cycle
    logic [PORT_W-1:0] floatPat = 8'h55;

    always @(posedge core_clk) begin
        floatPat <= ~floatPat;
    end

    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (pinOe[i]) begin
                pinLvl[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinLvl[i] = extVal[i];
            end else if (pullUp[i]) begin
                pinLvl[i] = 1'b1;
            end else begin
                pinLvl[i] = floatPat[i];
            end
        end
    end
endmodule // gpb_pin_model

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench of the port pair over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import gpb_pkg::*;
    logic core_clk, nrst, ce, awvalid, wvalid, bready, arvalid, rready, wakeReq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  aIn, aOut, aOe, aPu, aAn, aIrq, bIn, bOut, bOe, bPu, bAn, bIrq;
    logic [7:0]  extEn, extVal;
    int mismatches, checks, cyc;

    gpb_port_pair i_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .portAPinIn(aIn), .portAPinOut(aOut), .portAPinOe(aOe), .portAPullUp(aPu),
        .portAAnalog(aAn), .portAExtIrq(aIrq), .portBPinIn(bIn), .portBPinOut(bOut),
        .portBPinOe(bOe), .portBPullUp(bPu), .portBAnalog(bAn), .portBExtIrq(bIrq),
        .wakeReq(wakeReq));
    gpb_pin_model i_pinA (.core_clk(core_clk), .pinOe(aOe), .pinOut(aOut),
        .pullUp(aPu), .extEn(8'h00), .extVal(8'h00), .pinLvl(aIn));
    gpb_pin_model i_pinB (.core_clk(core_clk), .pinOe(bOe), .pinOut(bOut),
        .pullUp(bPu), .extEn(extEn), .extVal(extVal), .pinLvl(bIn));

    // ----
    // Clock, reset, hang limit
    // ----
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aT, wT, bT;
        logic [1:0] r;
        bT = 1'b0;
        @(posedge core_clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bT) begin
            @(negedge core_clk);
            aT = awvalid && awready;
            wT = wvalid && wready;
            bT = bvalid;
            r = bresp;
            @(posedge core_clk);
            if (aT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
            if (bT) bready <= 1'b0;
        end
        chk(32'(r), 32'(er));
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
        logic aT, rT;
        logic [31:0] d;
        logic [1:0] r;
        rT = 1'b0;
        @(posedge core_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rT) begin
            @(negedge core_clk);
            aT = arvalid && arready;
            rT = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (aT) arvalid <= 1'b0;
            if (rT) rready <= 1'b0;
        end
        chk(d, {24'h0, e});
        chk(32'(r), 32'(er));
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        settle(1);
        chk(32'({aPu, bPu, aOe, bOe}), 32'hFFFF0000);
        chk(32'({aAn, bAn, aIrq, bIrq}), 32'h0);
        rd(IDX_PA_DATA, 8'hFF, RESP_OKAY);
        rd(IDX_PB_DIR, 8'h00, RESP_OKAY);
        rd(IDX_PA_OPT, 8'h00, RESP_OKAY);
        $display("test reset done");
    endtask

    task automatic t_input();
        // Whole-byte writes; unbonded pins 2 and 4 stay at reset
        wr(IDX_PB_DATA, 8'h0A, RESP_OKAY);
        wr(IDX_PB_OPT, 8'h09, RESP_OKAY);
        settle(1);
        chk(32'(bPu), 32'hF5);
        chk(32'(bAn), 32'h08);
        chk(32'({bOe, bIrq}), 32'h0);
        @(posedge core_clk);
        extEn <= 8'hEB;
        extVal <= 8'hFA;
        settle(3);
        chk(32'({bIrq, wakeReq}), 32'h0);
        rd(IDX_PB_DATA, 8'hFE, RESP_OKAY);
        wr(IDX_CTRL, 8'h01, RESP_OKAY);
        settle(1);
        chk(32'({bIrq, wakeReq}), 32'h3);
        @(posedge core_clk);
        ce <= 1'b0;
        extVal <= 8'hFB;
        settle(3);
        chk(32'({bIrq, wakeReq}), 32'h3);
        @(posedge core_clk);
        ce <= 1'b1;
        settle(3);
        chk(32'({bIrq, wakeReq}), 32'h0);
        @(posedge core_clk);
        extVal <= 8'hFA;
        settle(3);
        chk(32'({bIrq, wakeReq}), 32'h3);
        wr(IDX_CTRL, 8'h00, RESP_OKAY);
        settle(1);
        chk(32'({bIrq, wakeReq}), 32'h0);
        $display("test input done");
    endtask

    task automatic t_output();
        wr(IDX_PA_DATA, 8'h35, RESP_OKAY);
        wr(IDX_PA_OPT, 8'h0F, RESP_OKAY);
        wr(IDX_PA_DIR, 8'hFF, RESP_OKAY);
        settle(1);
        chk(32'(aOe), 32'hCF);
        chk(32'(aOut & aOe), 32'h05);
        rd(IDX_PA_DATA, 8'h35, RESP_OKAY);
        rd(IDX_PA_DIR, 8'hFF, RESP_OKAY);
        rd(IDX_PA_OPT, 8'h0F, RESP_OKAY);
        rd(IDX_PB_OPT, 8'h09, RESP_OKAY);
        $display("test output done");
    endtask

    task automatic t_map();
        wr(IDX_PB_DIR, 8'hE0, RESP_OKAY);
        wr(IDX_PB_DATA, 8'h8A, RESP_OKAY);
        rd(IDX_PB_DATA, 8'h9E, RESP_OKAY);
        wr(10'h3F0, 8'h77, RESP_SLVERR);
        rd(10'h3F0, 8'h00, RESP_SLVERR);
        rd(IDX_PB_DIR, 8'hE0, RESP_OKAY);
        $display("test map done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 56'h0;
        {extEn, extVal} = 16'h0;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        ce = 1'b1;
        nrst = 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_input();
        t_output();
        t_map();
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
